// File: hw/audio_port_pkg.sv
// audio_port_pkg: register map, field layout and fixed figures of the
// shared I2S / PCM audio port; assumes a 32-bit AHB-Lite register slave.
package audio_port_pkg;
  localparam int BUS_W     = 32;
  localparam int DIV_W     = 16;
  localparam int PCM_CHANS = 3;
  localparam int SLOT_FLD  = 5;   // four slot bits and one enable per channel
  localparam int SLOT_EN   = 4;
  localparam int SAMPLE_BITS = 13;

  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_DIV    = 8'h04;
  localparam logic [7:0] A_SLOT   = 8'h08;
  localparam logic [7:0] A_TX0    = 8'h0C;
  localparam logic [7:0] A_TX1    = 8'h10;
  localparam logic [7:0] A_TX2    = 8'h14;
  localparam logic [7:0] A_RX0    = 8'h18;
  localparam logic [7:0] A_RX1    = 8'h1C;
  localparam logic [7:0] A_RX2    = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;

  // control and status register fields
  localparam int C_MODE_LO = 0;
  localparam int C_MODE_HI = 1;
  localparam int C_MASTER  = 2;
  localparam int C_I2S50   = 3;
  localparam int C_LONG    = 4;
  localparam int C_SLOT_LO = 5;
  localparam int C_SLOT_HI = 7;
  localparam int C_LSB1ST  = 8;
  localparam int C_RJUST   = 9;
  localparam int C_FILL_LO = 10;
  localparam int C_FILL_HI = 11;
  localparam int C_FVAL_LO = 12;
  localparam int C_FVAL_HI = 14;
  localparam int ST_FRM_LO = 8;

  localparam logic [14:0] CTRL_RST = 15'h0000;
  localparam logic [31:0] DIV_RST  = 32'h0000_0000;
  localparam logic [14:0] SLOT_RST = 15'h0000;

  localparam logic [1:0] MODE_I2S  = 2'h1;
  localparam logic [1:0] MODE_PCM  = 2'h2;
  localparam logic [1:0] FILL_ZERO = 2'h0;
  localparam logic [1:0] FILL_ONE  = 2'h1;
  localparam logic [1:0] FILL_SIGN = 2'h2;

  // frame figures
  localparam logic [7:0] I2S_FRAME_SHORT = 8'h20;  // 32 bits per frame
  localparam logic [7:0] I2S_FRAME_LONG  = 8'h32;  // 50 bits per frame
  localparam logic [7:0] LONG_SYNC_BITS  = 8'h03;
  localparam logic [2:0] SLOT_SEL_MAX    = 3'h4;   // 16 slots
  localparam logic [4:0] WORD_BITS       = 5'h10;
endpackage

// File: hw/div_if.sv
// div_if: control and tick of the fractional bit clock divider
// assumes the port core drives the settings and reads the tick
`timescale 1ns/10ps
`default_nettype none
interface div_if;
  logic                           en;
  logic [audio_port_pkg::DIV_W-1:0] n;
  logic [audio_port_pkg::DIV_W-1:0] m;
  logic                           tick;
  modport ctl (output en, output n, output m, input tick);
  modport div (input en, input n, input m, output tick);
endinterface
`default_nettype wire

// File: hw/frac_div.sv
// frac_div: N over M accumulator giving a one-cycle tick at clk*N/M
// assumes N < M; M of zero stops the tick
`timescale 1ns/10ps
`default_nettype none
module frac_div #(
  parameter int W = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  div_if.div        d
);
  import audio_port_pkg::*;

  logic [W:0] acc_q;
  logic [W:0] acc_d;
  logic       tick_q;

  // overflow of the phase accumulator marks one tick
  wire [W:0] sum = acc_q + {1'b0, d.n};
  wire       hit = d.en && (d.m != '0) && (sum >= {1'b0, d.m});
  assign acc_d  = !d.en ? '0 : (hit ? sum - {1'b0, d.m} : sum);
  assign d.tick = tick_q;

  // accumulator and tick register
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q  <= acc_d;
      tick_q <= hit;
    end
endmodule // frac_div
`default_nettype wire

// File: hw/audio_port.sv
// audio_port: shared I2S / PCM serial port with AHB-Lite registers
// assumes a 50 MHz hclk and a pad ring that resolves in/out/enable
`timescale 1ns/10ps
`default_nettype none
module audio_port (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic [audio_port_pkg::BUS_W-1:0] haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [audio_port_pkg::BUS_W-1:0] hwdata,
  input  wire logic                            hready,
  output logic                                 hreadyout,
  output logic                                 hresp,
  output logic [audio_port_pkg::BUS_W-1:0]     hrdata,
  input  wire logic                            bclk_i,
  output logic                                 bclk_o,
  output logic                                 bclk_oe,
  input  wire logic                            fs_i,
  output logic                                 fs_o,
  output logic                                 fs_oe,
  input  wire logic                            din_i,
  output logic                                 dout_o,
  output logic                                 dout_oe
);
  import audio_port_pkg::*;

  logic [14:0] ctrl_q;
  logic [31:0] div_q;
  logic [14:0] slot_q;
  logic [15:0] tx_q [PCM_CHANS];
  logic [15:0] rx_q [PCM_CHANS];
  logic [7:0]  frames_q;
  logic        wpend_q;
  logic [7:0]  waddr_q;
  logic [31:0] hrdata_q;
  logic        hrdy_q;
  logic [2:0]  sy1_q, sy2_q, sy3_q, stab_q;
  logic        bclk_q, boe_q, fs_q, fs_prev_q;
  logic [7:0]  cnt_q;
  logic        ws_r_q, half_ws_q, dbit_q, doe_q;
  logic [15:0] sr_q, racc_q;
  logic [4:0]  rxn_q;
  logic        rxch_q;

  div_if dv ();

  // helpers for the transmit and receive paths; pcm_word fills transmit words only
  function automatic logic [2:0] slot_hits(input logic [14:0] cfg,
                                           input logic [3:0]  s);
    slot_hits = 3'h0;
    for (int c = 0; c < PCM_CHANS; c++)
      slot_hits[c] = cfg[c*SLOT_FLD+SLOT_EN] && (cfg[c*SLOT_FLD +: 4] == s);
  endfunction

  function automatic logic [1:0] first_hit(input logic [2:0] h);
    first_hit = h[0] ? 2'h0 : (h[1] ? 2'h1 : 2'h2);
  endfunction

  function automatic logic [3:0] bit_idx(input logic [3:0] bp,
                                         input logic       lsb1st);
    bit_idx = lsb1st ? bp : 4'(4'hF - bp);
  endfunction

  function automatic logic [15:0] pcm_word(input logic [15:0] s,
                                           input logic [14:0] c);
    logic [2:0] f;
    case (c[C_FILL_HI:C_FILL_LO])
      FILL_ZERO: f = 3'h0;
      FILL_ONE:  f = 3'h7;
      FILL_SIGN: f = {3{s[SAMPLE_BITS-1]}};
      default:   f = c[C_FVAL_HI:C_FVAL_LO];
    endcase
    pcm_word = c[C_RJUST] ? {f, s[12:0]} : {s[12:0], f};
  endfunction

  // bus address phase decode and read selection
  wire        take   = hsel && htrans[1] && hready;
  wire [7:0]  ra     = haddr[7:0];
  wire        ra_ok  = haddr[31:8] == 24'h00_0000;
  wire [31:0] st_w   = {16'h0000, frames_q, 6'h00, doe_q, boe_q};
  wire [31:0] rd_mux = !ra_ok ? 32'h0000_0000 :
                       (ra == A_CTRL)   ? {17'h0_0000, ctrl_q} :
                       (ra == A_DIV)    ? div_q :
                       (ra == A_SLOT)   ? {17'h0_0000, slot_q} :
                       (ra == A_TX0)    ? {16'h0000, tx_q[0]} :
                       (ra == A_TX1)    ? {16'h0000, tx_q[1]} :
                       (ra == A_TX2)    ? {16'h0000, tx_q[2]} :
                       (ra == A_RX0)    ? {16'h0000, rx_q[0]} :
                       (ra == A_RX1)    ? {16'h0000, rx_q[1]} :
                       (ra == A_RX2)    ? {16'h0000, rx_q[2]} :
                       (ra == A_STATUS) ? st_w : 32'h0000_0000;

  // address phase capture; the slave stalls only until the first clock after reset and always says okay
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wpend_q  <= 1'b0;
      waddr_q  <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hrdy_q   <= 1'b0;
    end
    else
    begin
      hrdy_q   <= 1'b1;
      wpend_q  <= take && hwrite && ra_ok;
      waddr_q  <= take ? ra : waddr_q;
      hrdata_q <= (take && !hwrite) ? rd_mux : 32'h0000_0000;
    end

  // data phase register writes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctrl_q <= CTRL_RST;
      div_q  <= DIV_RST;
      slot_q <= SLOT_RST;
      for (int c = 0; c < PCM_CHANS; c++)
        tx_q[c] <= 16'h0000;
    end
    else if (wpend_q)
      case (waddr_q)
        A_CTRL:  ctrl_q  <= hwdata[14:0];
        A_DIV:   div_q   <= hwdata;
        A_SLOT:  slot_q  <= hwdata[14:0];
        A_TX0:   tx_q[0] <= hwdata[15:0];
        A_TX1:   tx_q[1] <= hwdata[15:0];
        A_TX2:   tx_q[2] <= hwdata[15:0];
        default: ;
      endcase

  // mode and frame geometry
  wire [1:0] mode     = ctrl_q[C_MODE_HI:C_MODE_LO];
  wire       i2s_on   = mode == MODE_I2S;
  wire       pcm_on   = mode == MODE_PCM;
  wire       on       = i2s_on || pcm_on;
  wire       master   = ctrl_q[C_MASTER];
  wire       long_fs  = ctrl_q[C_LONG];
  wire       lsb1st   = ctrl_q[C_LSB1ST];
  wire [2:0] ssel_raw = ctrl_q[C_SLOT_HI:C_SLOT_LO];
  wire [2:0] ssel     = ssel_raw > SLOT_SEL_MAX ? SLOT_SEL_MAX : ssel_raw;
  wire [3:0] smask    = 4'((5'h01 << ssel) - 5'h01);
  wire [7:0] pcm_last = {smask, 4'hF};
  wire [7:0] i2s_len  = ctrl_q[C_I2S50] ? I2S_FRAME_LONG : I2S_FRAME_SHORT;
  wire [7:0] i2s_half = i2s_len >> 1;
  wire [7:0] cnt_last = i2s_on ? 8'(i2s_len - 8'h01) : pcm_last;
  wire [7:0] cnt_nx   = (cnt_q == cnt_last) ? 8'h00 : 8'(cnt_q + 8'h01);

  // divider settings
  assign dv.en = on && master;
  assign dv.n  = div_q[DIV_W-1:0];
  assign dv.m  = div_q[BUS_W-1:DIV_W];

  frac_div #(
    .W (DIV_W)
  ) u_div (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (dv.div)
  );

  // three-stage synchronisers for bit clock, frame sync and data pins
  wire [2:0] pin_in = {din_i, fs_i, bclk_i};
  wire [2:0] agree  = ~(sy2_q ^ sy3_q);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sy1_q  <= 3'h0;
      sy2_q  <= 3'h0;
      sy3_q  <= 3'h0;
      stab_q <= 3'h0;
    end
    else
    begin
      sy1_q  <= pin_in;
      sy2_q  <= sy1_q;
      sy3_q  <= sy2_q;
      stab_q <= (agree & sy3_q) | (~agree & stab_q);
    end

  // bit clock edges: own divider as master, accepted pin edges as slave
  wire s_edge  = agree[0] && (sy3_q[0] != stab_q[0]);
  wire rise_ev = on && (master ? dv.tick && !bclk_q : s_edge && sy3_q[0]);
  wire fall_ev = on && (master ? dv.tick && bclk_q : s_edge && !sy3_q[0]);
  wire fs_in   = stab_q[1];
  wire din     = stab_q[2];

  // master bit clock and pin direction
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bclk_q <= 1'b0;
      boe_q  <= 1'b0;
    end
    else
    begin
      boe_q  <= on && master;
      bclk_q <= !(on && master) ? 1'b0 : bclk_q ^ dv.tick;
    end

  // bit counter and frame sync / word select generation
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt_q     <= 8'h00;
      fs_q      <= 1'b0;
      fs_prev_q <= 1'b0;
      ws_r_q    <= 1'b0;
    end
    else if (!on)
    begin
      cnt_q     <= 8'h00;
      fs_q      <= 1'b0;
      fs_prev_q <= 1'b0;
      ws_r_q    <= 1'b0;
    end
    else if (i2s_on)
    begin
      if (fall_ev && master)
      begin
        cnt_q <= cnt_nx;
        fs_q  <= cnt_nx >= i2s_half;
      end
      if (rise_ev)
        ws_r_q <= master ? fs_q : fs_in;
    end
    else if (rise_ev)
    begin
      cnt_q <= cnt_nx;
      if (master)
        fs_q <= long_fs ? cnt_nx < LONG_SYNC_BITS : cnt_nx == pcm_last;
    end
    else if (fall_ev)
    begin
      fs_prev_q <= fs_in;
      if (!master && fs_in && !long_fs)
        cnt_q <= pcm_last;
      else if (!master && fs_in && !fs_prev_q)
        cnt_q <= 8'h00;
    end

  // transmit word selection
  wire        ws_turn = ws_r_q != half_ws_q;
  wire [15:0] i2s_w   = ws_r_q ? tx_q[1] : tx_q[0];
  wire [2:0]  tx_hit  = slot_hits(slot_q, cnt_nx[7:4]);
  wire [15:0] pw      = pcm_word(tx_q[first_hit(tx_hit)], ctrl_q);
  wire        pbit    = pw[bit_idx(cnt_nx[3:0], lsb1st)];

  // serial data out and its driver enable
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dbit_q    <= 1'b0;
      doe_q     <= 1'b0;
      sr_q      <= 16'h0000;
      half_ws_q <= 1'b0;
    end
    else if (!on)
    begin
      dbit_q    <= 1'b0;
      doe_q     <= 1'b0;
      sr_q      <= 16'h0000;
      half_ws_q <= 1'b0;
    end
    else if (i2s_on)
    begin
      doe_q <= 1'b1;
      if (fall_ev && ws_turn)
      begin
        half_ws_q <= ws_r_q;
        dbit_q    <= i2s_w[15];
        sr_q      <= {i2s_w[14:0], 1'b0};
      end
      else if (fall_ev)
      begin
        dbit_q <= sr_q[15];
        sr_q   <= {sr_q[14:0], 1'b0};
      end
    end
    else if (rise_ev)
    begin
      doe_q  <= |tx_hit;
      dbit_q <= pbit;
    end
    else if (fall_ev && cnt_q[3:0] == 4'hF)
      doe_q <= 1'b0;

  // receive assembly
  wire [2:0]  rx_hit  = slot_hits(slot_q, cnt_q[7:4]);
  wire [1:0]  rx_ch   = first_hit(rx_hit);
  wire [3:0]  rbi     = bit_idx(cnt_q[3:0], lsb1st);
  wire [15:0] racc_nx = (racc_q & ~(16'h0001 << rbi)) | ({15'h0000, din} << rbi);
  wire [15:0] i2s_rx  = {racc_q[14:0], din};
  wire [12:0] rx_smp  = ctrl_q[C_RJUST] ? racc_nx[12:0] : racc_nx[15:3];
  wire        i2s_fin = i2s_on && rise_ev && rxn_q == 5'(WORD_BITS - 5'h01);
  wire        pcm_fin = pcm_on && fall_ev && |rx_hit && cnt_q[3:0] == 4'hF;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      racc_q <= 16'h0000;
      rxn_q  <= WORD_BITS;
      rxch_q <= 1'b0;
    end
    else if (!on)
      rxn_q <= WORD_BITS;
    else if (i2s_on && fall_ev && ws_turn)
    begin
      rxn_q  <= 5'h00;
      rxch_q <= ws_r_q;
    end
    else if (i2s_on && rise_ev && rxn_q != WORD_BITS)
    begin
      racc_q <= i2s_rx;
      rxn_q  <= 5'(rxn_q + 5'h01);
    end
    else if (pcm_on && fall_ev && |rx_hit)
      racc_q <= racc_nx;

  // received words and frame counter
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      for (int c = 0; c < PCM_CHANS; c++)
        rx_q[c] <= 16'h0000;
      frames_q <= 8'h00;
    end
    else
    begin
      if (i2s_fin)
        rx_q[{1'b0, rxch_q}] <= i2s_rx;
      else if (pcm_fin)
        rx_q[rx_ch] <= {3'h0, rx_smp};
      if ((i2s_on && fall_ev && ws_turn && !ws_r_q) ||
          (pcm_on && rise_ev && cnt_nx == 8'h00))
        frames_q <= 8'(frames_q + 8'h01);
    end

  assign hreadyout = hrdy_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign bclk_o    = bclk_q;
  assign bclk_oe   = boe_q;
  assign fs_o      = fs_q;
  assign fs_oe     = boe_q;
  assign dout_o    = dbit_q;
  assign dout_oe   = doe_q;

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_ws_turn;
    i2s_on && fall_ev && ws_turn;
  endsequence
  sequence s_sync_seen;
    pcm_on && !master && !long_fs && fall_ev && fs_in;
  endsequence

  property p_master_pins;
    (i2s_on && master) [*2] |-> bclk_oe && fs_oe && dout_oe;
  endproperty
  a_master_pins: assert property (p_master_pins) else $error("pin dir");
  property p_off_quiet;
    (!on) [*2] |-> !bclk_oe && !fs_oe && !dout_oe && !bclk_o && !fs_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("idle drive");
  property p_msb_first;
    s_ws_turn |=> dout_o == $past(i2s_w[15]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb");
  property p_fall_launch;
    i2s_on && $past(i2s_on) && $changed(dout_o) |-> $past(fall_ev);
  endproperty
  a_fall_launch: assert property (p_fall_launch) else $error("edge");
  property p_ws_pos;
    i2s_on && master && $past(i2s_on) && $changed(fs_o)
      |-> cnt_q == (fs_o ? i2s_half : 8'h00);
  endproperty
  a_ws_pos: assert property (p_ws_pos) else $error("ws position");
  property p_div_clock;
    on && master && dv.tick ##1 on && master |-> $changed(bclk_o);
  endproperty
  a_div_clock: assert property (p_div_clock) else $error("divider");
  property p_slot_own;
    pcm_on && $rose(dout_oe) |-> $past(rise_ev && |tx_hit);
  endproperty
  a_slot_own: assert property (p_slot_own) else $error("slot");
  property p_release;
    pcm_on && fall_ev && cnt_q[3:0] == 4'hF ##1 pcm_on |-> !dout_oe;
  endproperty
  a_release: assert property (p_release) else $error("release");
  property p_short_sync;
    pcm_on && master && !long_fs && $rose(fs_o) |-> cnt_q == pcm_last;
  endproperty
  a_short_sync: assert property (p_short_sync) else $error("short");
  property p_slave_lock;
    s_sync_seen |=> cnt_q == pcm_last;
  endproperty
  a_slave_lock: assert property (p_slave_lock) else $error("lock");
  property p_long_sync;
    pcm_on && master && long_fs && fs_o |-> cnt_q < LONG_SYNC_BITS;
  endproperty
  a_long_sync: assert property (p_long_sync) else $error("long");
  property p_count_span;
    pcm_on |-> cnt_q <= pcm_last;
  endproperty
  a_count_span: assert property (p_count_span) else $error("slots");
endmodule // audio_port
`default_nettype wire

// File: sim/codec_model.sv
// codec_model: far-side I2S codec, clock master while lead is high
// assumes the bench resolves the shared lines and feeds them back
`timescale 1ns/10ps
`default_nettype none
module codec_model (
  input  wire logic        hclk,
  input  wire logic        rst_n,
  input  wire logic        lead,
  input  wire logic [15:0] l_w,
  input  wire logic [15:0] r_w,
  input  wire logic        bclk,
  input  wire logic        ws,
  input  wire logic        dout,
  output logic             bclk_d,
  output logic             ws_d,
  output logic             sync_d,
  output logic             din_d,
  output logic [15:0]      cap_l,
  output logic [15:0]      cap_r
);
  logic [3:0]  ph_q;
  logic [4:0]  b_q;
  logic [4:0]  nb;
  logic [15:0] sh_q;
  logic [5:0]  c_q;
  logic        wl_q;
  assign nb = b_q + 5'h01;

  // 2.5 MHz bit clock, still when idle; ws and data move on falls
  always @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n || !lead)
    begin
      ph_q   <= 4'h0;
      b_q    <= 5'h1F;
      bclk_d <= 1'b0;
      ws_d   <= rst_n && !ws_d; // released line toggles
      sync_d <= 1'b0;
      din_d  <= rst_n && !din_d;
    end
    else if (ph_q != 4'h9)
      ph_q <= ph_q + 4'h1;
    else
    begin
      ph_q   <= 4'h0;
      bclk_d <= !bclk_d;
      if (bclk_d)
      begin
        b_q   <= nb;
        ws_d  <= nb[4];
        din_d <= b_q[4] ? r_w[~b_q[3:0]] : l_w[~b_q[3:0]];
      end
      else
        sync_d <= b_q == 5'h1F;
    end
  end

  // sample on rises; a word ends 16 rises after ws turns
  always @(posedge bclk)
  begin
    sh_q <= {sh_q[14:0], dout};
    if (c_q == 6'h0F && wl_q)
      cap_r <= {sh_q[14:0], dout};
    if (c_q == 6'h0F && !wl_q)
      cap_l <= {sh_q[14:0], dout};
    c_q  <= (ws != wl_q) ? 6'h00 : c_q + 6'h01;
    wl_q <= ws;
  end
endmodule // codec_model
`default_nettype wire

// File: sim/tb_top.sv
// tb_top: self-checking bench for the shared audio port
// assumes codec_model on the serial pins and an AHB-Lite master here
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import audio_port_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, lead;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [15:0] l_w, r_w, cap_l, cap_r, l, r;
  logic        hreadyout, hresp, bclk_o, bclk_oe, fs_o, fs_oe;
  logic        dout_o, dout_oe, bclk_d, ws_d, din_i;
  logic        bclk_i, fs_i, dout_w, sync_d, pcm_s;
  logic        rd_q = 1'b0;
  logic [31:0] exp_q[$];
  int          errors = 0;
  int          total_checks = 0;
  int          i, f, c, s;

  // pads: whoever enables drives; a floating data line wiggles
  assign bclk_i = bclk_oe ? bclk_o : bclk_d;
  assign fs_i   = fs_oe ? fs_o : (pcm_s ? sync_d : ws_d);
  assign dout_w = dout_oe ? dout_o : hclk;

  audio_port i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .bclk_i, .bclk_o, .bclk_oe, .fs_i,
    .fs_o, .fs_oe, .din_i, .dout_o, .dout_oe
  );
  codec_model i_codec (
    .hclk, .rst_n(hresetn), .lead, .l_w, .r_w, .bclk(bclk_i),
    .ws(fs_i), .dout(dout_w), .bclk_d, .ws_d, .sync_d, .din_d(din_i),
    .cap_l, .cap_r
  );

  always #10 hclk = !hclk;

  task finish_test;
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task to;
    errors++;
    finish_test();
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // compare each read's data with the oldest note
  always @(posedge hclk)
  begin
    if (rd_q && hreadyout)
    begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, hresp);
    end
    rd_q <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  task wt;
    int n;
    for (n = 0; n < 50; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    if (n == 50)
      to();
  endtask

  // one single word transfer, then an idle cycle
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wt();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    @(posedge hclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // hclk count and bit clock rises between two ws falls
  task frm;
    logic fp, bp;
    int   n;
    c  = -1;
    s  = 0;
    fp = 1'b0;
    bp = 1'b0;
    for (n = 0; n < 9000; n++)
    begin
      @(posedge hclk);
      if (c >= 0)
        c++;
      if (c >= 0 && bclk_i && !bp)
        s++;
      if (fp && !fs_i && c > 0)
        break;
      if (fp && !fs_i)
        c = 0;
      fp = fs_i;
      bp = bclk_i;
    end
    if (n == 9000)
      to();
  endtask

  // wait for bclk_o to reach v after a full transition
  task edge_to(input logic v);
    logic p;
    int   n;
    p = v;
    for (n = 0; n < 400; n++)
    begin
      @(posedge hclk);
      if (bclk_o === v && p !== v)
        break;
      p = bclk_o;
    end
    if (n == 400)
      to();
  endtask

  // one 2-slot PCM master frame, channel 0 owning slot 1
  // ones fill also right justifies, sign fill also sends LSB first
  task pcm(input logic lng, input logic [1:0] fl, input logic [12:0] sm,
           input logic [2:0] fv);
    logic [31:0] cw;
    logic [15:0] w;
    logic        pf;
    logic        rj, lf;
    logic [2:0]  fb;
    int          k, b;
    rj = fl == 2'h1;
    lf = fl == 2'h2;
    fb = fl == 2'h0 ? 3'h0 : fl == 2'h1 ? 3'h7 :
         fl == 2'h2 ? {3{sm[12]}} : fv;
    w  = rj ? {fb, sm} : {sm, fb};
    cw = {17'h0, fv, fl, rj, lf, 3'h1, lng, 2'h1, MODE_PCM};
    bus(1'b1, A_CTRL, 32'h0);
    bus(1'b1, A_TX0, {19'h0, sm});
    bus(1'b1, A_CTRL, cw);
    rd(A_CTRL, cw);
    chk("pcm_oe", 32'h3, {bclk_oe, fs_oe});
    pf = 1'b1;
    for (k = 0; k < 80; k++)
    begin
      edge_to(1'b1);
      if (fs_o === 1'b1 && (!lng || !pf))
        break;
      pf = fs_o;
    end
    if (k == 80)
      to();
    for (b = 0; b < 32; b++)
    begin
      if (b > 0 || !lng)
        edge_to(1'b1);
      chk("sync", lng ? b < 3 : b == 31, fs_o);
      chk("dout_oe", b >= 16, dout_oe);
      if (b >= 16)
        chk("dout", w[lf ? b - 16 : 31 - b], dout_o);
    end
    edge_to(1'b0);
    chk("oe_end", 32'h0, dout_oe);
  endtask

  initial
  begin
    hclk    = 1'b0;
    hresetn = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    lead    = 1'b0;
    pcm_s   = 1'b0;
    l_w     = 16'h0;
    r_w     = 16'h0;
    void'($urandom(32'h0E410D56));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, dropped writes, unmapped space
    rd(A_CTRL, 32'h0);
    rd(A_DIV, DIV_RST);
    rd(A_SLOT, 32'h0);
    bus(1'b1, A_RX0, 32'hFFFF_FFFF);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(A_RX0, 32'h0);
    rd(8'h40, 32'h0);
    chk("idle_oe", 32'h0, {bclk_oe, fs_oe, dout_oe});
    // master frames of 32 and 50 bits from the fractional divider
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, A_CTRL, 32'h0);
      l = 16'($urandom);
      r = 16'($urandom);
      bus(1'b1, A_TX0, {16'h0, l});
      bus(1'b1, A_TX1, {16'h0, r});
      bus(1'b1, A_DIV, i ? {16'h007D, 16'h0008} : {16'h0C35, 16'h0080});
      bus(1'b1, A_CTRL, {28'h0, i[0], 1'b1, MODE_I2S});
      frm();
      chk("bits", i ? 50 : 32, s);
      chk("period", 1, c >= 1562 && c <= 1563);
      frm();
      chk("left", l, cap_l);
      chk("right", r, cap_r);
      chk("m_oe", 32'h7, {bclk_oe, fs_oe, dout_oe});
    end
    // slave: codec leads the clocks in both directions
    bus(1'b1, A_CTRL, {30'h0, MODE_I2S});
    l_w  <= 16'($urandom);
    r_w  <= 16'($urandom);
    lead <= 1'b1;
    frm();
    frm();
    chk("s_oe", 32'h1, {bclk_oe, fs_oe, dout_oe});
    chk("s_left", r ^ r ^ l, cap_l);
    rd(A_RX0, {16'h0, l_w});
    rd(A_RX1, {16'h0, r_w});
    lead <= 1'b0;
    // switched off: no clock, every driver released
    bus(1'b1, A_CTRL, 32'h3);
    s = 0;
    repeat (200)
    begin
      @(posedge hclk);
      if ({bclk_o, bclk_oe, fs_oe, dout_oe} !== 4'h0)
        s++;
    end
    chk("off", 0, s);
    // PCM slave: codec sends clock and short sync, no slot owned
    pcm_s <= 1'b1;
    bus(1'b1, A_CTRL, 32'h22);
    lead  <= 1'b1;
    frm();
    frm();
    chk("ps_oe", 32'h0, {bclk_oe, fs_oe, dout_oe});
    lead  <= 1'b0;
    pcm_s <= 1'b0;
    // PCM master: every fill kind, then long sync
    bus(1'b1, A_DIV, {16'h0005, 16'h0001});
    bus(1'b1, A_SLOT, 32'h11);
    for (f = 0; f < 5; f++)
      pcm(f == 4, f[1:0], 13'($urandom), 3'($urandom));
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
